// [design/dlv_device.sv]
// Purpose: Display-side input stage: lane decode, line and frame tracking, absent-input fill.
// Assumes: Runs on the link clock; signal presence is sensed by the core clock.
// Notes: Sync bits in the lanes are not decoded and never used for timing.
`timescale 1ns/1ps
`default_nettype none
module dlv_device
    import dlv_pkg::*;
#(
    parameter int ABSENT_CORE_CLOCKS = 64
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    dlv_link_if.dev link,
    input wire logic map_jeida_strap,
    input wire logic no_input_pattern_strap,
    output logic [PIX_BITS-1:0] pix_one_r,
    output logic [PIX_BITS-1:0] pix_two_r,
    output logic pix_valid_r,
    output logic line_start_r,
    output logic frame_start_r,
    output logic signal_present_r,
    output logic [1:0] source_r
);
    wire logic lclk;
    assign lclk = link.link_clk;

    // Strap synchronisers on the link clock.
    logic [1:0] map_sync_r;
    logic [1:0] pat_sync_r;
    always_ff @(posedge lclk or negedge reset_n) begin
        if (!reset_n) begin
            map_sync_r <= 2'b00;
            pat_sync_r <= 2'b00;
        end else if (clk_en) begin
            map_sync_r <= {map_sync_r[0], map_jeida_strap};
            pat_sync_r <= {pat_sync_r[0], no_input_pattern_strap};
        end
    end

    // Decode one link's lanes into pixel and enable.
    function automatic logic [PIX_BITS:0] decode(input logic [LANES*LANE_BITS-1:0] w,
                                                 input logic jeida);
        logic [6:0] a;
        logic [6:0] b;
        logic [6:0] c;
        logic [6:0] d;
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] bl;
        a = w[6:0];
        b = w[13:7];
        c = w[20:14];
        d = w[27:21];
        if (jeida) begin
            // Upper six bits on lanes A-C, low two bits on lane D.
            r = {a[5:0], d[1:0]};
            g = {a[6], b[4:0], d[3:2]};
            bl = {b[6:5], c[3:0], d[5:4]};
        end else begin
            // Low six bits on lanes A-C, upper two bits on lane D.
            r = {d[1:0], a[5:0]};
            g = {d[3:2], b[4:0], a[6]};
            bl = {d[5:4], c[3:0], b[6:5]};
        end
        // Data enable is slot 6 of lane C in both variants; sync slots ignored.
        decode = {c[6], r, g, bl};
    endfunction

    logic [PIX_BITS:0] dec_one;
    logic [PIX_BITS:0] dec_two;
    always_comb begin
        dec_one = decode(link.link_one_lanes, map_sync_r[1]);
        dec_two = decode(link.link_two_lanes, map_sync_r[1]);
    end
    wire logic de_in;
    assign de_in = dec_one[PIX_BITS];

    // Line and frame tracking from data enable alone.
    logic de_d_r;
    logic [11:0] gap_cnt_r;
    logic [10:0] line_cnt_r;
    logic [9:0] pat_x_r;
    logic lnk_toggle_r;
    always_ff @(posedge lclk or negedge reset_n) begin
        if (!reset_n) begin
            de_d_r <= 1'b0;
            gap_cnt_r <= 12'h000;
            line_start_r <= 1'b0;
            frame_start_r <= 1'b0;
            line_cnt_r <= 11'h000;
            lnk_toggle_r <= 1'b0;
        end else if (clk_en) begin
            de_d_r <= de_in;
            line_start_r <= de_in && !de_d_r;
            // A gap longer than a full line period marks the next line as first.
            frame_start_r <= de_in && !de_d_r && (gap_cnt_r > 12'(LINE_PERIOD_MAX));
            if (de_in) begin
                gap_cnt_r <= 12'h000;
            end else if (gap_cnt_r != 12'hFFF) begin
                gap_cnt_r <= gap_cnt_r + 12'h001;
            end
            if (de_in && !de_d_r) begin
                line_cnt_r <= (gap_cnt_r > 12'(LINE_PERIOD_MAX)) ? 11'h000 : line_cnt_r + 11'h001;
            end
            // Activity toggle lets the core domain see the link running.
            lnk_toggle_r <= ~lnk_toggle_r;
        end
    end

    // Presence sensed on core clock: the link clock may stop, so it cannot time itself out.
    logic [2:0] tog_sync_r;
    logic [7:0] quiet_cnt_r;
    logic present_core_r;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tog_sync_r <= 3'b000;
            quiet_cnt_r <= 8'h00;
            present_core_r <= 1'b0;
        end else if (clk_en) begin
            tog_sync_r <= {tog_sync_r[1:0], lnk_toggle_r};
            if (tog_sync_r[2] != tog_sync_r[1]) begin
                quiet_cnt_r <= 8'h00;
                present_core_r <= 1'b1;
            end else if (quiet_cnt_r == 8'(ABSENT_CORE_CLOCKS)) begin
                present_core_r <= 1'b0;
            end else begin
                quiet_cnt_r <= quiet_cnt_r + 8'h01;
            end
        end
    end

    // Presence level back into the link domain for output selection.
    logic [1:0] pres_sync_r;
    always_ff @(posedge lclk or negedge reset_n) begin
        if (!reset_n) begin
            pres_sync_r <= 2'b00;
        end else if (clk_en) begin
            pres_sync_r <= {pres_sync_r[0], present_core_r};
        end
    end

    // Presence flag reported on the core clock.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            signal_present_r <= 1'b0;
        end else if (clk_en) begin
            signal_present_r <= present_core_r;
        end
    end

    // Generated pattern: vertical colour bars stepping every 128 pixels.
    always_ff @(posedge lclk or negedge reset_n) begin
        if (!reset_n) begin
            pat_x_r <= 10'h000;
        end else if (clk_en) begin
            pat_x_r <= de_in ? pat_x_r + 10'h001 : 10'h000;
        end
    end
    logic [PIX_BITS-1:0] bar;
    always_comb begin
        bar = {{8{pat_x_r[9]}}, {8{pat_x_r[8]}}, {8{pat_x_r[7]}}};
    end

    // Pixel select. Without a live link this domain only runs while the host clocks it.
    always_ff @(posedge lclk or negedge reset_n) begin
        if (!reset_n) begin
            pix_one_r <= 24'h000000;
            pix_two_r <= 24'h000000;
            pix_valid_r <= 1'b0;
        end else if (clk_en) begin
            pix_valid_r <= de_in;
            if (pres_sync_r[1]) begin
                // Live input: pass the decoded pixels straight through.
                pix_one_r <= dec_one[PIX_BITS-1:0];
                pix_two_r <= dec_two[PIX_BITS-1:0];
            end else if (pat_sync_r[1]) begin
                // Input missing with the pattern strap high: show the bars.
                pix_one_r <= bar;
                pix_two_r <= bar;
            end else begin
                // Input missing with the pattern strap low: show black.
                pix_one_r <= 24'h000000;
                pix_two_r <= 24'h000000;
            end
        end
    end

    // Fill-choice strap synchronised on the core clock as well, because the link
    // clock is exactly what goes missing when the source has to switch to a fill.
    logic [1:0] pat_core_sync_r;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pat_core_sync_r <= 2'b00;
        end else if (clk_en) begin
            pat_core_sync_r <= {pat_core_sync_r[0], no_input_pattern_strap};
        end
    end

    // Source report on the core clock, so that it still moves while the link clock stops.
    // Limitation: the pixel words live on the link clock and keep their last value while
    // it is stopped; they carry the fill from the first link edges after it returns.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            source_r <= DLV_SRC_BLACK;
        end else if (clk_en) begin
            if (present_core_r) begin
                source_r <= DLV_SRC_LIVE;
            end else if (pat_core_sync_r[1]) begin
                // Pattern strap high: generated bars while the input is missing.
                source_r <= DLV_SRC_PATTERN;
            end else begin
                // Pattern strap low: black while the input is missing.
                source_r <= DLV_SRC_BLACK;
            end
        end
    end
endmodule
`default_nettype wire

// [design/dlv_host.sv]
// Purpose: Host-side video timing source driving both links in data-enable-only form.
// Assumes: Link clock is core clock divided by DIV (even).
// Notes: Pixels come from the user port and are taken at each active link clock.
`timescale 1ns/1ps
`default_nettype none
module dlv_host
    import dlv_pkg::*;
#(
    parameter int DIV = 2,
    parameter int H_ACTIVE = LINE_ACTIVE_CLOCKS,
    parameter int H_BLANK = LINE_BLANK_TYP, // Margin above the minimum blank
    parameter int V_ACTIVE = FRAME_ACTIVE_LINES,
    parameter int V_BLANK = FRAME_BLANK_TYP // Sets frame rate with the clock
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    dlv_link_if.host link,
    input wire logic map_jeida,
    input wire logic [PIX_BITS-1:0] pix_one,
    input wire logic [PIX_BITS-1:0] pix_two,
    output logic pix_take_r,
    output logic frame_start_r
);
    logic [7:0] div_r;
    logic lclk_r;
    logic [11:0] h_r;
    logic [11:0] v_r;
    logic [LANES*LANE_BITS-1:0] one_r;
    logic [LANES*LANE_BITS-1:0] two_r;
    assign link.link_clk = lclk_r;
    assign link.link_one_lanes = one_r;
    assign link.link_two_lanes = two_r;

    // Encode one pixel into lane words, matching the strap variant.
    function automatic logic [LANES*LANE_BITS-1:0] enc(input logic [PIX_BITS-1:0] p,
                                                       input logic de, input logic j);
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
        logic [6:0] a;
        logic [6:0] bb;
        logic [6:0] c;
        logic [6:0] d;
        r = p[RED_LSB+7:RED_LSB];
        g = p[GRN_LSB+7:GRN_LSB];
        b = p[BLU_LSB+7:BLU_LSB];
        if (j) begin
            a = {g[7], r[7:2]};
            bb = {b[7:6], g[6:2]};
            c = {de, 2'b00, b[5:2]};
            d = {1'b0, b[1:0], g[1:0], r[1:0]};
        end else begin
            a = {g[0], r[5:0]};
            bb = {b[1:0], g[5:1]};
            c = {de, 2'b00, b[5:2]};
            d = {1'b0, b[7:6], g[7:6], r[7:6]};
        end
        enc = {d, c, bb, a};
    endfunction

    // Clock divider and pixel/line counters advanced on each link-clock fall.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_r <= 8'h00;
            lclk_r <= 1'b0;
            h_r <= 12'h000;
            v_r <= 12'h000;
            one_r <= '0;
            two_r <= '0;
            pix_take_r <= 1'b0;
            frame_start_r <= 1'b0;
        end else if (clk_en) begin
            pix_take_r <= 1'b0;
            frame_start_r <= 1'b0;
            if (div_r == 8'(DIV/2 - 1)) begin
                div_r <= 8'h00;
                lclk_r <= ~lclk_r;
                if (lclk_r) begin
                    // Falling edge: launch the next word, stable for the device's rising edge.
                    if (h_r == 12'(H_ACTIVE + H_BLANK - 1)) begin
                        h_r <= 12'h000;
                        v_r <= (v_r == 12'(V_ACTIVE + V_BLANK - 1)) ? 12'h000 : v_r + 12'h001;
                    end else begin
                        h_r <= h_r + 12'h001;
                    end
                    if (h_r < 12'(H_ACTIVE) && v_r < 12'(V_ACTIVE)) begin
                        one_r <= enc(pix_one, 1'b1, map_jeida);
                        two_r <= enc(pix_two, 1'b1, map_jeida);
                        pix_take_r <= 1'b1;
                        frame_start_r <= (h_r == 12'h000) && (v_r == 12'h000);
                    end else begin
                        one_r <= enc(24'h000000, 1'b0, map_jeida);
                        two_r <= enc(24'h000000, 1'b0, map_jeida);
                    end
                end
            end else begin
                div_r <= div_r + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// [pkg/dlv_link_if.sv]
// Purpose: Dual LVDS link carrier between host and display input.
// Assumes: Lanes carry deserialized 7-bit slot words per link clock.
// Notes: Host drives everything; both links share one forwarded clock here.
`timescale 1ns/1ps
`default_nettype none
interface dlv_link_if;
    import dlv_pkg::*;
    // Forwarded link clock, made by the host.
    logic link_clk;
    // Lane words A..D for link one and link two.
    logic [LANES*LANE_BITS-1:0] link_one_lanes;
    logic [LANES*LANE_BITS-1:0] link_two_lanes;
    // Host drives the link.
    modport host (output link_clk, output link_one_lanes, output link_two_lanes);
    // Device receives the link.
    modport dev (input link_clk, input link_one_lanes, input link_two_lanes);
endinterface
`default_nettype wire

// [pkg/dlv_pkg.sv]
// Purpose: Shared constants and types for the dual-link video input timing ends.
// Assumes: Link words are already deserialized; one link-clock edge per pixel pair.
// Notes: Counts are in link clocks unless named otherwise.
//
// Contract
// - Strap high selects JEIDA mapping, else VESA.
// - Two links, four data lanes plus clock.
// - Strap low: black screen when input absent; only source_r reports black, the pixel words keep their last value.
// - Strap high: generated pattern when input absent; only source_r reports the pattern, the pixel words keep their last value.
// - Timing from data enable only; syncs ignored.
// - Host meets every interface timing limit except frame rate; its default frame rate is about 40.4 Hz, below both ranges.
// - Data enable lasts 960 clocks per link.
// - Horizontal blank 100 to 240 clocks.
// - Exactly 1080 active lines per frame.
// - Vertical blank 20-69 or 228-300 lines.
// - Frame rate 57-63 or 47-53 Hz; the host defaults give about 40.4 Hz (10 ns core clock, DIV 2).
// - Spread spectrum: add margin above minimums.
package dlv_pkg;
    // Horizontal timing in link clocks.
    localparam int LINE_ACTIVE_CLOCKS = 960;
    localparam int LINE_BLANK_MIN = 100;
    localparam int LINE_BLANK_TYP = 140;
    localparam int LINE_BLANK_MAX = 240;
    localparam int LINE_PERIOD_MAX = LINE_ACTIVE_CLOCKS + LINE_BLANK_MAX;
    // Vertical timing in lines.
    localparam int FRAME_ACTIVE_LINES = 1080;
    localparam int FRAME_BLANK_TYP = 45;
    // Core clock and its period in ns.
    localparam int CORE_CLK_NS = 10;
    // Width of one lane word per link clock (7-bit LVDS slot).
    localparam int LANE_BITS = 7;
    localparam int LANES = 4;
    // Pixel word: 8 bits each of red, green, blue.
    localparam int PIX_BITS = 24;
    // Field positions of the decoded pixel.
    localparam int RED_LSB = 16;
    localparam int GRN_LSB = 8;
    localparam int BLU_LSB = 0;
    // Mapping variant selected by strap.
    typedef enum logic {
        DLV_MAP_VESA = 1'b0,
        DLV_MAP_JEIDA = 1'b1
    } dlv_map_t;
    // Device output source.
    typedef enum logic [1:0] {
        DLV_SRC_LIVE = 2'b00,
        DLV_SRC_BLACK = 2'b01,
        DLV_SRC_PATTERN = 2'b11
    } dlv_src_t;
endpackage

// [verif/dlv_link_chk.sv]
// Purpose: Wire checks on the dual video link between host and device ends.
// Assumes: Data enable rides in lane C bit 6 of each link word.
// Notes: Counters run on the link clock, so a frozen host pauses them.
`timescale 1ns/1ps
`default_nettype none
module dlv_link_chk
    import dlv_pkg::*;
#(
    parameter int H_ACTIVE = LINE_ACTIVE_CLOCKS,
    parameter int H_BLANK = LINE_BLANK_TYP,
    parameter int V_ACTIVE = FRAME_ACTIVE_LINES,
    parameter int V_BLANK = FRAME_BLANK_TYP
) (
    input wire logic link_clk,
    input wire logic reset_n,
    input wire logic [LANES*LANE_BITS-1:0] link_one_lanes,
    input wire logic [LANES*LANE_BITS-1:0] link_two_lanes
);
    logic de; // Enable of link one; link two must match it.
    logic [15:0] run_r; // Clocks of enable high so far.
    logic [15:0] gap_r; // Clocks of enable low so far.
    logic [15:0] lines_r; // Lines seen in the current frame.
    assign de = link_one_lanes[20];
    // High run length; cleared as soon as enable drops.
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            run_r <= 16'h0000;
        end else begin
            run_r <= de ? run_r + 16'h0001 : 16'h0000;
        end
    end
    // Low run length, used to tell line gaps from frame gaps.
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            gap_r <= 16'h0000;
        end else begin
            gap_r <= de ? 16'h0000 : gap_r + 16'h0001;
        end
    end
    // Line count restarts at a long gap, so it holds the last frame's total there.
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            lines_r <= 16'h0000;
        end else if (de && run_r == 16'h0000) begin
            lines_r <= (gap_r > 16'(LINE_PERIOD_MAX)) ? 16'h0001 : lines_r + 16'h0001;
        end
    end
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!reset_n);
    // Together these hold the host to the timing set by H_ACTIVE, H_BLANK, V_ACTIVE and V_BLANK.
    de_run_len_a: assert property ($fell(de) |-> run_r == H_ACTIVE)
        else $error("enable run length wrong");
    de_no_glitch_a: assert property ($rose(de) |=> de [*8])
        else $error("enable dropped early");
    // The first line after reset has no blank before it, so it is left out here.
    line_blank_a: assert property ($rose(de) && gap_r <= 16'(LINE_PERIOD_MAX)
        && lines_r != 16'h0000 |-> gap_r == H_BLANK)
        else $error("line blank length wrong");
    blank_min_a: assert property ($fell(de) |=> !de [*8])
        else $error("line blank too short");
    link_pair_a: assert property (de == link_two_lanes[20])
        else $error("links out of step");
    frame_lines_a: assert property ($rose(de) && gap_r > 16'(LINE_PERIOD_MAX)
        && lines_r != 16'h0000 |-> lines_r == V_ACTIVE)
        else $error("active line count wrong");
    lines_bound_a: assert property ($rose(de) && gap_r <= 16'(LINE_PERIOD_MAX)
        |-> lines_r < V_ACTIVE)
        else $error("too many lines in frame");
    frame_blank_a: assert property ($rose(de) && gap_r > 16'(LINE_PERIOD_MAX)
        && lines_r != 16'h0000
        |-> gap_r == V_BLANK * (H_ACTIVE + H_BLANK) + H_BLANK)
        else $error("frame blank length wrong");
    frame_seen_c: cover property ($rose(de) && gap_r > 16'(LINE_PERIOD_MAX)
        && lines_r != 16'h0000);
    line_seen_c: cover property ($rose(de) && gap_r <= 16'(LINE_PERIOD_MAX));
    run_end_c: cover property ($fell(de));
endmodule
`default_nettype wire

// [verif/dual_link_video_input_timing_test.sv]
// Purpose: Self-checking bench joining host and device ends over both links.
// Assumes: Frames are shortened to 2 active and 2 blank lines.
// Notes: The host divides its clock to make the link clock; the bench never does.
`timescale 1ns/1ps
`default_nettype none
module dual_link_video_input_timing_test;
    import dlv_pkg::*;
    localparam int VA = 2; // Active lines, shortened to keep the run brief.
    localparam int VB = 2; // Blank lines, still a gap above one line period.
    localparam int FRAME = (VA + VB) * (LINE_ACTIVE_CLOCKS + LINE_BLANK_TYP);
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic host_en = 1'b1; // Low freezes the host, so the link goes silent.
    logic dev_en = 1'b1;
    logic host_map = 1'b0;
    logic dev_map = 1'b0;
    logic pat_strap = 1'b0;
    logic [PIX_BITS-1:0] pone = 24'h000000;
    logic [PIX_BITS-1:0] ptwo = 24'h000000;
    logic [PIX_BITS-1:0] got_one, got_two;
    logic valid, lstart, fstart, present, take, host_fs;
    logic [1:0] src;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    int takes = 0; // Host pixel takes, counted at the core falling edge where they settle.
    int host_frames = 0; // Host frame-start pulses, counted the same way.
    // The host pulses last one core clock, so they are tallied here rather than on the link.
    always @(negedge core_clk) begin
        takes += int'(take === 1'b1);
        host_frames += int'(host_fs === 1'b1);
    end
    dlv_link_if link();
    dlv_host #(.V_ACTIVE(VA), .V_BLANK(VB)) i_dlv_host (.core_clk(core_clk),
        .reset_n(reset_n), .clk_en(host_en), .link(link), .map_jeida(host_map),
        .pix_one(pone), .pix_two(ptwo), .pix_take_r(take), .frame_start_r(host_fs));
    dlv_device #(.ABSENT_CORE_CLOCKS(16)) i_dlv_device (.core_clk(core_clk),
        .reset_n(reset_n), .clk_en(dev_en), .link(link), .map_jeida_strap(dev_map),
        .no_input_pattern_strap(pat_strap), .pix_one_r(got_one), .pix_two_r(got_two),
        .pix_valid_r(valid), .line_start_r(lstart), .frame_start_r(fstart),
        .signal_present_r(present), .source_r(src));
    dlv_link_chk #(.H_ACTIVE(LINE_ACTIVE_CLOCKS), .H_BLANK(LINE_BLANK_TYP), .V_ACTIVE(VA),
        .V_BLANK(VB)) i_dlv_link_chk (.link_clk(link.link_clk), .reset_n(reset_n),
        .link_one_lanes(link.link_one_lanes), .link_two_lanes(link.link_two_lanes));
    // Core clock at 100 MHz.
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("Counts: %0d checks, %0d mismatches", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Samples at the link clock's falling edge, where device outputs have settled.
    task automatic wait_frame();
        int n;
        n = 0;
        do begin
            @(negedge link.link_clk);
            n++;
        end while (fstart !== 1'b1 && n < 2 * FRAME);
        check("frame start", {31'h0, fstart}, 32'h1);
    endtask
    task automatic test_timing();
        int n, de_n, ls_n, t0, f0;
        wait_frame();
        n = 0;
        de_n = 0;
        ls_n = 0;
        t0 = takes;
        f0 = host_frames;
        do begin
            @(negedge link.link_clk);
            n++;
            de_n += int'(valid === 1'b1);
            ls_n += int'(lstart === 1'b1);
        end while (fstart !== 1'b1 && n < 2 * FRAME);
        check("frame length", n, FRAME);
        check("active clocks", de_n, VA * LINE_ACTIVE_CLOCKS);
        check("line starts", ls_n, VA);
        check("host takes", takes - t0, VA * LINE_ACTIVE_CLOCKS);
        check("host frames", host_frames - f0, 1);
        $display("Test timing done");
    endtask
    // Unequal straps must garble the pixel; equal ones must pass it intact.
    task automatic test_pixels(input logic hm, input logic dm);
        @(negedge core_clk);
        host_map = hm;
        dev_map = dm;
        pone = hm ? 24'hC3A55A : 24'h3C5AA5;
        ptwo = pone ^ 24'h0F1E2D;
        repeat (16) @(negedge link.link_clk);
        wait_frame();
        repeat (4) @(negedge link.link_clk);
        if (hm == dm) begin
            check("pixel one", {8'h00, got_one}, {8'h00, pone});
            check("pixel two", {8'h00, got_two}, {8'h00, ptwo});
        end else begin
            check("map differs", {31'h0, got_one !== pone}, 32'h1);
        end
        check("source live", {30'h0, src}, {30'h0, DLV_SRC_LIVE});
        $display("Test pixels done");
    endtask
    // Silence the host, check the fill source, then bring the link back.
    task automatic test_absent(input logic p);
        int n;
        @(negedge core_clk);
        pat_strap = p;
        host_en = 1'b0;
        n = 0;
        while (present !== 1'b0 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        repeat (4) @(negedge core_clk);
        check("present low", {31'h0, present}, 32'h0);
        check("fill source", {30'h0, src}, {30'h0, p ? DLV_SRC_PATTERN : DLV_SRC_BLACK});
        host_en = 1'b1;
        n = 0;
        while (src !== DLV_SRC_LIVE && n < 4 * FRAME) begin
            @(negedge core_clk);
            n++;
        end
        check("source back", {30'h0, src}, {30'h0, DLV_SRC_LIVE});
        $display("Test absent done");
    endtask
    // A hang is cut short well above the expected run of about 44000 cycles.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 90000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
        reset_n = 1'b1;
        test_timing();
        test_pixels(1'b1, 1'b1);
        test_pixels(1'b0, 1'b0);
        test_pixels(1'b1, 1'b0);
        test_absent(1'b0);
        test_absent(1'b1);
        give_verdict();
    end
endmodule
`default_nettype wire
